/* core/pmta_table_unit.sv */
// Purpose: table read and table write unit with APB registers
// Assumes: 100 MHz clock, synchronous active low reset, APB master
// Notes:   commands issued by writing the command register
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
module pmta_table_unit (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        vpp_present,
  input  wire logic [3:0]  int_set,
  input  wire logic [15:0] ext_rdata,
  output logic      [15:0] ext_addr,
  output logic      [15:0] ext_wdata,
  output logic             ext_we,
  output logic             ext_oe,
  output logic             core_halted,
  output logic             vector_req
);
  typedef enum logic [1:0] {ST_IDLE, ST_CYC2, ST_LONG} pmta_state_type;

  pmta_state_type state_reg;
  logic [15:0] ptr_reg;
  logic [15:0] wr_latch_reg;
  logic [15:0] rd_latch_reg;
  logic [7:0]  result_reg;
  logic [1:0]  cfg_reg;
  logic [3:0]  en_reg;
  logic [3:0]  flag_reg;
  logic [1:0]  op_reg;
  logic        ext_op_reg;
  logic        inc_reg;
  logic        vpp_meta_reg;
  logic        vpp_sync_reg;
  logic [31:0] prdata_reg;
  logic        pready_reg;
  logic        pslverr_reg;
  logic [15:0] ext_addr_reg;
  logic [15:0] ext_wdata_reg;
  logic        ext_we_reg;
  logic        ext_oe_reg;
  logic        halted_reg;
  logic        vector_reg;
  logic [15:0] mem_rdata;

  logic        apb_wr;
  logic        cmd_go;
  logic [1:0]  cmd_op;
  logic        cmd_sel;
  logic        cmd_inc;
  logic [7:0]  cmd_data;
  logic        ext_mode;
  logic        gid;
  logic        pend;
  logic        go_lwrite;
  logic        go_write;
  logic        go_lread;
  logic        go_read;
  logic        w_abort;
  logic        w_long;
  logic        term;
  logic        rd_done;
  logic        wr_done;
  logic [15:0] rd_word;
  logic [15:0] wr_word_next;
  logic [3:0]  hw_clr;
  logic [3:0]  sw_clr;

  // highest priority set bit among the core sources
  function automatic logic [3:0] pmta_first(input logic [3:0] v);
    logic [3:0] m;
    m = 4'h0;
    for (int i = 2; i >= 0; i--)
    begin
      if (v[i])
      begin
        m = 4'h1 << i;
      end
    end
    return m;
  endfunction : pmta_first

  // command decode
  assign apb_wr   = psel & penable & pready_reg & pwrite & ~pslverr_reg;
  assign cmd_go   = apb_wr & (paddr == pmta_pkg::OFF_COMMAND);
  assign cmd_op   = pwdata[pmta_pkg::CMD_OP_LSB +: 2];
  assign cmd_sel  = pwdata[pmta_pkg::CMD_SEL_BIT];
  assign cmd_inc  = pwdata[pmta_pkg::CMD_INC_BIT];
  assign cmd_data = pwdata[pmta_pkg::CMD_DATA_LSB +: 8];
  assign ext_mode = cfg_reg[pmta_pkg::CFG_EXT_BIT];
  assign gid      = cfg_reg[pmta_pkg::CFG_GID_BIT];
  assign pend     = |(en_reg & flag_reg);
  assign go_lwrite = cmd_go & (cmd_op == pmta_pkg::OP_LATCH_BYTE_WRITE);
  assign go_write  = cmd_go & (cmd_op == pmta_pkg::OP_PROGRAM_WORD_WRITE);
  assign go_lread  = cmd_go & (cmd_op == pmta_pkg::OP_LATCH_BYTE_READ);
  assign go_read   = cmd_go & (cmd_op == pmta_pkg::OP_PROGRAM_WORD_READ);
  // pending interrupt turns internal write into no-op
  assign w_abort = go_write & ~ext_mode & pend;
  // internal write with voltage starts long write
  assign w_long  = go_write & ~ext_mode & ~pend & vpp_sync_reg;
  // only an enabled flagged source ends it
  assign term    = (state_reg == ST_LONG) & pend;
  assign rd_done = (state_reg == ST_CYC2) & (op_reg == pmta_pkg::OP_PROGRAM_WORD_READ);
  assign wr_done = ((state_reg == ST_CYC2) & (op_reg == pmta_pkg::OP_PROGRAM_WORD_WRITE)) | term;
  assign rd_word = ext_op_reg ? ext_rdata : mem_rdata;
  assign wr_word_next = cmd_sel ? {cmd_data, wr_latch_reg[7:0]} : {wr_latch_reg[15:8], cmd_data};
  // clear highest core flag on termination
  assign hw_clr  = (term | w_abort) ? pmta_first(en_reg & flag_reg & pmta_pkg::CORE_SRC_MASK) : 4'h0;
  assign sw_clr  = (apb_wr & (paddr == pmta_pkg::OFF_IRQ)) ? pwdata[pmta_pkg::IRQ_FLAG_LSB +: 4] : 4'h0;

  // programming voltage pin synchroniser
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      vpp_meta_reg <= 1'b0;
      vpp_sync_reg <= 1'b0;
    end
    else
    begin
      vpp_meta_reg <= vpp_present;
      vpp_sync_reg <= vpp_meta_reg;
    end
  end

  // apb answer prepared in the setup cycle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
    end
    else
    begin
      pready_reg  <= psel & ~penable;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h0;
      case (paddr)
        pmta_pkg::OFF_POINTER: prdata_reg <= {16'h0, ptr_reg};
        pmta_pkg::OFF_COMMAND: pslverr_reg <= pwrite & (state_reg != ST_IDLE);
        pmta_pkg::OFF_STATUS:  prdata_reg <= {21'h0, vpp_sync_reg, halted_reg,
                                              state_reg != ST_IDLE, result_reg};
        pmta_pkg::OFF_CONFIG:  prdata_reg <= {30'h0, cfg_reg};
        pmta_pkg::OFF_IRQ:     prdata_reg <= {20'h0, flag_reg, 4'h0, en_reg};
        pmta_pkg::OFF_LATCH:   prdata_reg <= {rd_latch_reg, wr_latch_reg};
        default:               pslverr_reg <= 1'b1;
      endcase
    end
  end

  // configuration and interrupt enables
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      cfg_reg <= pmta_pkg::CFG_RESET;
      en_reg  <= 4'h0;
    end
    else if (apb_wr && paddr == pmta_pkg::OFF_CONFIG)
    begin
      cfg_reg <= pwdata[1:0];
    end
    else if (apb_wr && paddr == pmta_pkg::OFF_IRQ)
    begin
      en_reg <= pwdata[3:0];
    end
  end

  // interrupt flags, a new event wins over any clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      flag_reg <= 4'h0;
    end
    else
    begin
      flag_reg <= (flag_reg & ~sw_clr & ~hw_clr) | int_set;
    end
  end

  // sequencer
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (w_long)
          begin
            state_reg <= ST_LONG;
          end
          // no voltage gives plain two-cycle write
          else if (go_read || (go_write && !w_abort))
          begin
            state_reg <= ST_CYC2;
          end
        end
        ST_CYC2: state_reg <= ST_IDLE;
        ST_LONG:
        begin
          if (term)
          begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // operation held for the second cycle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      op_reg     <= pmta_pkg::OP_LATCH_BYTE_WRITE;
      ext_op_reg <= 1'b0;
      inc_reg    <= 1'b0;
    end
    else if (cmd_go)
    begin
      op_reg     <= cmd_op;
      ext_op_reg <= ext_mode;
      inc_reg    <= cmd_inc;
    end
  end

  // pointer, software write takes priority
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ptr_reg <= pmta_pkg::PTR_RESET;
    end
    else if (apb_wr && paddr == pmta_pkg::OFF_POINTER)
    begin
      ptr_reg <= pwdata[15:0];
    end
    else if ((rd_done || wr_done) && inc_reg)
    begin
      ptr_reg <= ptr_reg + 16'h0001;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      wr_latch_reg <= pmta_pkg::LATCH_RESET;
    end
    else if (go_lwrite || go_write)
    begin
      wr_latch_reg <= wr_word_next;
    end
    // read reloads the write latch only when internal
    else if (rd_done && !ext_op_reg)
    begin
      wr_latch_reg <= rd_word;
    end
  end

  // read latch, shared with the write latch when internal
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      rd_latch_reg <= pmta_pkg::LATCH_RESET;
    end
    // reload after the byte was taken
    else if (rd_done)
    begin
      rd_latch_reg <= rd_word;
    end
    else if ((go_lwrite || go_write) && !ext_mode)
    begin
      rd_latch_reg <= wr_word_next;
    end
  end

  // one latch byte returned per instruction
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      result_reg <= 8'h00;
    end
    else if (go_lread || go_read)
    begin
      result_reg <= cmd_sel ? rd_latch_reg[15:8] : rd_latch_reg[7:0];
    end
  end

  // external write strobe in the second cycle
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      ext_we_reg    <= 1'b0;
      ext_oe_reg    <= 1'b0;
      ext_addr_reg  <= 16'h0000;
      ext_wdata_reg <= 16'h0000;
    end
    else
    begin
      ext_we_reg <= go_write & ext_mode;
      ext_oe_reg <= go_read & ext_mode;
      if (cmd_go && ext_mode)
      begin
        ext_addr_reg  <= ptr_reg;
        ext_wdata_reg <= wr_word_next;
      end
    end
  end

  // vector only when interrupt disable is clear
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      halted_reg <= 1'b0;
      vector_reg <= 1'b0;
    end
    else
    begin
      halted_reg <= w_long | ((state_reg == ST_LONG) & ~term);
      vector_reg <= term & ~gid;
    end
  end

  // internal program memory, written when the long write ends
  pmta_word_mem u_mem (
    .clock     (clock),
    .wr_en     (term),
    .rd_en     (go_read & ~ext_mode),
    .addr      (ptr_reg[pmta_pkg::MEM_AW-1:0]),
    .wdata     (wr_latch_reg),
    .rdata_reg (mem_rdata)
  );

  assign prdata      = prdata_reg;
  assign pready      = pready_reg;
  assign pslverr     = pslverr_reg;
  assign ext_addr    = ext_addr_reg;
  assign ext_wdata   = ext_wdata_reg;
  assign ext_we      = ext_we_reg;
  assign ext_oe      = ext_oe_reg;
  assign core_halted = halted_reg;
  assign vector_req  = vector_reg;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_long_start;
    go_write && !ext_mode && !pend && vpp_sync_reg;
  endsequence
  sequence s_ext_write;
    go_write && ext_mode;
  endsequence

  a_long_halt: assert property (s_long_start ##1 !pend |-> core_halted [*2]) else $error("long write no halt");
  a_long_hold: assert property (core_halted && !pend |=> core_halted) else $error("long write ended early");
  a_novpp_short: assert property (go_write && !ext_mode && !pend && !vpp_sync_reg
    |=> !core_halted ##1 state_reg == ST_IDLE) else $error("no-voltage write not two cycles");
  a_abort_clear: assert property (w_abort && flag_reg[0] && en_reg[0] && !int_set[0]
    |=> !flag_reg[0] && state_reg == ST_IDLE) else $error("abort did not clear flag");
  a_periph_keep: assert property (term && (en_reg & flag_reg) == 4'h8
    |=> flag_reg[3]) else $error("peripheral flag cleared");
  a_vector_gid: assert property (term |=> vector_req == !$past(gid)) else $error("vector decision wrong");
  a_ext_twocyc: assert property (s_ext_write |=> ext_we ##1 !ext_we) else $error("external write timing");
  a_ptr_inc: assert property (go_read && cmd_inc && !(psel && paddr == pmta_pkg::OFF_POINTER)
    |=> ##1 ptr_reg == $past(ptr_reg, 2) + 16'h0001) else $error("pointer not incremented");
  a_ext_latch: assert property (rd_done && ext_op_reg |=> $stable(wr_latch_reg)) else $error("write latch disturbed");
endmodule : pmta_table_unit
`default_nettype wire

/* core/pmta_pkg.sv */
// Purpose: constants for the program word table access unit
// Assumes: 100 MHz core clock, APB register access, 32-bit data
// Notes:   register offsets are byte addresses on the APB
package pmta_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_POINTER = 12'h000;
  localparam logic [11:0] OFF_COMMAND = 12'h004;
  localparam logic [11:0] OFF_STATUS  = 12'h008;
  localparam logic [11:0] OFF_CONFIG  = 12'h00c;
  localparam logic [11:0] OFF_IRQ     = 12'h010;
  localparam logic [11:0] OFF_LATCH   = 12'h014;
  // command fields
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_OP_LSB   = 8;
  localparam int CMD_SEL_BIT  = 10;
  localparam int CMD_INC_BIT  = 11;
  // instruction codes
  localparam logic [1:0] OP_LATCH_BYTE_WRITE  = 2'h0;
  localparam logic [1:0] OP_PROGRAM_WORD_WRITE = 2'h1;
  localparam logic [1:0] OP_LATCH_BYTE_READ   = 2'h2;
  localparam logic [1:0] OP_PROGRAM_WORD_READ  = 2'h3;
  // status and config fields
  localparam int STAT_BUSY_BIT = 8;
  localparam int STAT_LONG_BIT = 9;
  localparam int STAT_VPP_BIT  = 10;
  localparam int CFG_EXT_BIT   = 0;
  localparam int CFG_GID_BIT   = 1;
  localparam int IRQ_FLAG_LSB  = 8;
  // interrupt sources, lowest index has highest priority
  localparam int SRC_EXT_PIN  = 0;
  localparam int SRC_TIMER    = 1;
  localparam int SRC_TIMER_CK = 2;
  localparam int SRC_PERIPH   = 3;
  localparam logic [3:0] CORE_SRC_MASK = 4'h7;
  // reset values
  localparam logic [15:0] PTR_RESET   = 16'h0000;
  localparam logic [1:0]  CFG_RESET   = 2'h2;
  localparam logic [15:0] LATCH_RESET = 16'h0000;
  // internal program memory size
  localparam int MEM_AW = 8;
  localparam int MEM_DEPTH = 256;
endpackage : pmta_pkg

/* core/pmta_word_mem.sv */
// Purpose: internal program word store with registered read data
// Assumes: single clock, one write or read per cycle
// Notes:   read data appear the cycle after the read request
`timescale 1ns/100ps
`default_nettype none
module pmta_word_mem (
  input  wire logic                        clock,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  input  wire logic [pmta_pkg::MEM_AW-1:0] addr,
  input  wire logic [15:0]                 wdata,
  output logic      [15:0]                 rdata_reg
);
  logic [15:0] store [pmta_pkg::MEM_DEPTH];

  // word write
  always_ff @(posedge clock)
  begin
    if (wr_en)
    begin
      store[addr] <= wdata;
    end
  end

  // registered word read
  always_ff @(posedge clock)
  begin
    if (rd_en)
    begin
      rdata_reg <= store[addr];
    end
  end
endmodule : pmta_word_mem
`default_nettype wire

/* bench/pmta_ext_mem.sv */
// Purpose: external program memory model on the system bus
// Assumes: write strobe and read enable are one-cycle pulses
// Notes:   released data lines show the inverse of the last word read
`timescale 1ns/100ps
`default_nettype none
module pmta_ext_mem (
  input  wire logic        clock,
  input  wire logic [15:0] ext_addr,
  input  wire logic [15:0] ext_wdata,
  input  wire logic        ext_we,
  input  wire logic        ext_oe,
  output logic      [15:0] ext_rdata
);
  logic [15:0] mem_reg [0:65535];
  logic [15:0] last_reg;

  // fill with an address pattern so reads are never unknown
  initial
  begin
    for (int i = 0; i < 65536; i++)
      mem_reg[i] = 16'(i) ^ 16'hc3a5;
    last_reg = 16'h0000;
  end

  // word stored from the second write cycle
  always @(posedge clock)
  begin
    if (ext_we === 1'b1)
      mem_reg[ext_addr] <= ext_wdata;
    if (ext_oe === 1'b1)
      last_reg <= mem_reg[ext_addr];
  end

  // bus released outside the read pulse
  assign ext_rdata = (ext_oe === 1'b1) ? mem_reg[ext_addr] : ~last_reg;
endmodule : pmta_ext_mem
`default_nettype wire

/* bench/tb_pmta_table_unit.sv */
// Purpose: random and corner checks of the table access unit
// Assumes: zero wait APB slave, external memory model on the bus
// Notes:   expectations come from bench functions only
`timescale 1ns/100ps
`default_nettype none
module tb_pmta_table_unit;
  localparam logic [11:0] A_PTR = pmta_pkg::OFF_POINTER;
  localparam logic [11:0] A_CMD = pmta_pkg::OFF_COMMAND;
  localparam logic [11:0] A_ST  = pmta_pkg::OFF_STATUS;
  localparam logic [11:0] A_CFG = pmta_pkg::OFF_CONFIG;
  localparam logic [11:0] A_IRQ = pmta_pkg::OFF_IRQ;
  localparam logic [11:0] A_LAT = pmta_pkg::OFF_LATCH;
  localparam logic [1:0]  OP_LW = pmta_pkg::OP_LATCH_BYTE_WRITE;
  localparam logic [1:0]  OP_WW = pmta_pkg::OP_PROGRAM_WORD_WRITE;
  localparam logic [1:0]  OP_LR = pmta_pkg::OP_LATCH_BYTE_READ;
  localparam logic [1:0]  OP_WR = pmta_pkg::OP_PROGRAM_WORD_READ;
  logic        clock, rst_n, psel, penable, pwrite, pready, pslverr, e;
  logic        vpp_present, ext_we, ext_oe, core_halted, vector_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] ext_rdata, ext_addr, ext_wdata, a, w, last_waddr, last_wdata;
  logic [3:0]  int_set;
  int          err_total, compares, w0, v0, h0, seed;
  int          wcnt = 0, vcnt = 0, hcnt = 0;

  pmta_table_unit u_pmta_table_unit (.clock, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .vpp_present, .int_set, .ext_rdata, .ext_addr, .ext_wdata,
    .ext_we, .ext_oe, .core_halted, .vector_req);
  pmta_ext_mem u_pmta_ext_mem (.clock, .ext_addr, .ext_wdata, .ext_we, .ext_oe, .ext_rdata);

  // clock at 100 MHz
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // event counters and last external write
  always @(posedge clock)
  begin
    wcnt <= wcnt + int'(ext_we === 1'b1);
    vcnt <= vcnt + int'(vector_req === 1'b1);
    hcnt <= hcnt + int'(core_halted === 1'b1);
    if (ext_we === 1'b1)
    begin
      last_waddr <= ext_addr;
      last_wdata <= ext_wdata;
    end
  end

  function automatic logic [31:0] cw(logic [1:0] op, logic s, logic i, logic [7:0] d);
    return {24'h0, d} | (32'(op) << pmta_pkg::CMD_OP_LSB) | (32'(s) << pmta_pkg::CMD_SEL_BIT)
      | (32'(i) << pmta_pkg::CMD_INC_BIT);
  endfunction : cw

  function automatic logic [15:0] pat(logic [15:0] x);
    return x ^ 16'hc3a5;
  endfunction : pat

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x)
    begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", n, x, s);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
                     output logic [31:0] rq, output logic re);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do @(posedge clock); while (pready !== 1'b1 && ++n < 50);
    chk("apb_ready", {31'h0, pready}, 32'h1);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cmd(input logic [1:0] op, input logic s, input logic i, input logic [7:0] d);
    int n;
    apb(1'b1, A_CMD, cw(op, s, i, d), q, e);
    chk("cmd_err", {31'h0, e}, 32'h0);
    n = 0;
    do apb(1'b0, A_ST, 32'h0, q, e); while (q[pmta_pkg::STAT_BUSY_BIT] !== 1'b0 && ++n < 20);
    chk("busy_clear", {31'h0, q[pmta_pkg::STAT_BUSY_BIT]}, 32'h0);
  endtask : cmd

  task automatic vfy(input logic [15:0] ad, input logic [15:0] x);
    apb(1'b1, A_PTR, {16'h0, ad}, q, e);
    // dummy read fills the latch first
    cmd(OP_WR, 1'b0, 1'b0, 8'h00);
    cmd(OP_LR, 1'b1, 1'b0, 8'h00);
    chk("high_byte", {24'h0, q[7:0]}, {24'h0, x[15:8]});
    cmd(OP_WR, 1'b0, 1'b1, 8'h00);
    chk("low_byte", {24'h0, q[7:0]}, {24'h0, x[7:0]});
    apb(1'b0, A_PTR, 32'h0, q, e);
    chk("pointer_inc", q, {16'h0, ad + 16'h1});
  endtask : vfy

  task automatic pulse(input logic [3:0] s);
    @(posedge clock);
    int_set <= s;
    @(posedge clock);
    int_set <= 4'h0;
  endtask : pulse

  task automatic lw_end(input logic [3:0] s);
    int n;
    pulse(s);
    n = 0;
    while (core_halted !== 1'b0 && n < 20)
    begin
      @(posedge clock);
      n++;
    end
    repeat (3) @(posedge clock);
    chk("halt_end", {31'h0, core_halted}, 32'h0);
  endtask : lw_end

  task automatic long_write(input logic [7:0] hi, input logic [7:0] lo);
    apb(1'b1, A_PTR, 32'h10, q, e);
    cmd(OP_LW, 1'b1, 1'b0, hi);
    apb(1'b1, A_CMD, cw(OP_WW, 1'b0, 1'b0, lo), q, e);
    repeat (4) @(posedge clock);
  endtask : long_write

  task automatic tally_and_finish;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // watchdog against a hung handshake
  initial
  begin
    #100000;
    err_total++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    seed = 32'h83d1befd;
    {err_total, compares} = '0;
    {rst_n, psel, penable, pwrite, vpp_present} = '0;
    paddr = 12'h000;
    pwdata = 32'h0;
    int_set = 4'h0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    apb(1'b0, A_CFG, 32'h0, q, e);
    chk("config_reset", q, 32'h2);
    apb(1'b0, 12'h0fc, 32'h0, q, e);
    chk("unmapped", {q[30:0], e}, 32'h1);
    apb(1'b1, A_CFG, 32'h3, q, e);
    for (int i = 0; i < 6; i++)
    begin
      a = (i == 0) ? 16'hffff : 16'($random(seed));
      w = 16'($random(seed));
      apb(1'b1, A_PTR, {16'h0, a}, q, e);
      cmd(OP_LW, 1'b1, 1'b0, w[15:8]);
      w0 = wcnt;
      cmd(OP_WW, 1'b0, i[0], w[7:0]);
      chk("we_count", 32'(wcnt - w0), 32'h1);
      chk("ext_word", {last_waddr, last_wdata}, {a, w});
      apb(1'b0, A_PTR, 32'h0, q, e);
      chk("pointer", q, {16'h0, a + {15'h0, i[0]}});
      vfy(a, w);
    end
    apb(1'b1, A_PTR, 32'hfff0, q, e);
    cmd(OP_WR, 1'b0, 1'b0, 8'h00);
    apb(1'b0, A_LAT, 32'h0, q, e);
    chk("split_latch", q, {pat(16'hfff0), w});
    // internal long write ended by a peripheral source
    w0 = wcnt;
    apb(1'b1, A_CFG, 32'h0, q, e);
    apb(1'b1, A_IRQ, 32'h8, q, e);
    vpp_present <= 1'b1;
    v0 = vcnt;
    long_write(w[15:8], w[7:0]);
    chk("halted", {31'h0, core_halted}, 32'h1);
    apb(1'b0, A_ST, 32'h0, q, e);
    chk("long_flag", {31'h0, q[pmta_pkg::STAT_LONG_BIT]}, 32'h1);
    apb(1'b1, A_CMD, cw(OP_LW, 1'b1, 1'b0, 8'h00), q, e);
    chk("busy_refused", {31'h0, e}, 32'h1);
    pulse(4'h2);
    repeat (3) @(posedge clock);
    chk("still_halted", {31'h0, core_halted}, 32'h1);
    lw_end(4'h8);
    chk("vectored", 32'(vcnt - v0), 32'h1);
    apb(1'b0, A_IRQ, 32'h0, q, e);
    chk("periph_flag", {28'h0, q[11:8]}, 32'ha);
    apb(1'b1, A_IRQ, 32'hf00, q, e);
    // no programming voltage leaves memory alone
    vpp_present <= 1'b0;
    repeat (4) @(posedge clock);
    h0 = hcnt;
    cmd(OP_LW, 1'b1, 1'b0, ~w[15:8]);
    cmd(OP_WW, 1'b0, 1'b0, ~w[7:0]);
    chk("short_write", 32'(hcnt - h0), 32'h0);
    vfy(16'h10, w);
    chk("no_ext_write", 32'(wcnt - w0), 32'h0);
    // core source with interrupt disable set
    apb(1'b1, A_CFG, 32'h2, q, e);
    apb(1'b1, A_IRQ, 32'h2, q, e);
    vpp_present <= 1'b1;
    v0 = vcnt;
    long_write(8'h5a, 8'ha5);
    lw_end(4'h2);
    chk("no_vector", 32'(vcnt - v0), 32'h0);
    apb(1'b0, A_IRQ, 32'h0, q, e);
    chk("core_flag", {28'h0, q[11:8]}, 32'h0);
    apb(1'b1, A_IRQ, 32'h3, q, e);
    pulse(4'h3);
    h0 = hcnt;
    cmd(OP_LW, 1'b1, 1'b0, 8'h11);
    cmd(OP_WW, 1'b0, 1'b0, 8'h22);
    chk("abort_halt", 32'(hcnt - h0), 32'h0);
    apb(1'b0, A_IRQ, 32'h0, q, e);
    chk("abort_flag", {28'h0, q[11:8]}, 32'h2);
    tally_and_finish();
  end
endmodule : tb_pmta_table_unit
`default_nettype wire
